//--- ebw_ctrl.sv
// External bus wait controller: pin sequencing, waits and ready handling
`timescale 1ns/1ps
`default_nettype none
module ebw_ctrl
    import ebw_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Configuration
    input wire logic bus_clock_out_disable,
    input wire logic [1:0] mux_region_select,
    input wire logic strobe_style_select,
    input wire logic global_wait_insert,
    input wire logic data_flash_wait,
    input wire logic [3:0] area_wait_disable,
    input wire logic [7:0] area_wait_count_reg,
    input wire logic [7:0] area_wait_extend_reg,
    input wire logic [3:0] chip_select_config,
    input wire logic byte_mode,
    input wire logic expansion_mode,
    // Access request
    input wire logic req_valid,
    output logic req_ready,
    input wire ebw_area_e req_area,
    input wire logic req_write,
    input wire logic [1:0] req_cs,
    input wire logic [19:0] req_addr,
    input wire logic [1:0] req_bytes,
    input wire logic [15:0] req_wdata,
    output logic done,
    output logic [15:0] rdata,
    // Bus pins
    output logic [19:0] addr_out,
    output logic [19:0] addr_pin_is_bus,
    output logic [15:0] data_out,
    output logic data_oe_n,
    input wire logic [15:0] data_in,
    output logic [3:0] cs_n,
    output logic [3:0] cs_pin_is_bus,
    output logic rd_n,
    output logic store_low_byte_n,
    output logic store_high_byte_n,
    output logic byte_high_enable_n,
    output logic ale,
    output logic bus_yield_ack_n,
    output logic bclk_out,
    output logic bclk_pin_is_bus,
    input wire logic ready_n_pin
);
    // ==========================================
    // Declarations
    ebw_state_e state_reg;
    logic phase_reg;
    logic [2:0] rdy_sync_reg;
    logic rdy_level_reg;
    logic hold_reg;
    logic first_reg;
    logic [3:0] bcnt_reg;
    logic mux_reg;
    logic use_rdy_reg;
    logic wr_reg;
    logic [1:0] bytes_reg;
    ebw_area_e area_reg;
    logic [15:0] wdata_reg;
    logic gwi_reg;
    logic bclk_dis_reg;
    logic style_reg;
    logic [1:0] msel_reg;
    logic [3:0] wdis_reg;
    logic [7:0] wcnt_reg;
    logic [7:0] wext_reg;
    logic [3:0] cscfg_reg;
    logic mux_area;
    logic full_mux;
    logic style_eff;
    logic [1:0] strb_on;
    logic [1:0] strb_off;
    logic rise_tick;
    logic fall_tick;
    logic start;
    ebw_len_if lif ();

    // Bus clock halves: high while phase_reg is 1
    assign rise_tick = ~phase_reg;
    assign fall_tick = phase_reg;
    assign start = (state_reg == EBW_ST_IDLE) && rise_tick && req_valid;
    assign full_mux = (msel_reg == EBW_MUX_ALL);
    // Area chosen for the multiplexed bus
    always_comb
    begin
        case (msel_reg)
            EBW_MUX_CS2: mux_area = (req_cs == 2'd2);
            EBW_MUX_CS1: mux_area = (req_cs == 2'd1);
            EBW_MUX_ALL: mux_area = 1'b1;
            default: mux_area = 1'b0;
        endcase
    end
    // Byte-wide bus forces the read/write/byte-high style
    assign style_eff = byte_mode ? 1'b0 : style_reg;
    // Strobe pin levels while active and idle
    assign strb_on = style_eff ? {~(req_write & req_bytes[1]), ~(req_write & req_bytes[0])}
                               : {~req_bytes[1], ~req_write};
    assign strb_off = style_eff ? 2'b11 : {byte_high_enable_n, 1'b1};

    // ==========================================
    // Cycle length decoder
    assign lif.area = req_area;
    assign lif.mux_area = mux_area;
    assign lif.write = req_write;
    assign lif.wait_dis = wdis_reg[req_cs];
    assign lif.gwi = gwi_reg;
    assign lif.flash_wait = data_flash_wait;
    assign lif.wait_cnt = wcnt_reg[2 * req_cs +: 2];
    assign lif.wait_ext = wext_reg[2 * req_cs +: 2];
    ebw_cycle_len u_len (
        .lif (lif)
    );

    // ==========================================
    // Configuration capture with reset values
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gwi_reg <= EBW_RST_GWI;
            wdis_reg <= EBW_RST_WAIT_DIS;
            wcnt_reg <= EBW_RST_WAIT_CNT;
            wext_reg <= EBW_RST_WAIT_EXT;
            cscfg_reg <= EBW_RST_CS_CFG;
            msel_reg <= EBW_RST_MUX_SEL;
            bclk_dis_reg <= EBW_RST_BCLK_DIS;
            style_reg <= EBW_RST_STYLE;
        end
        else if (state_reg == EBW_ST_IDLE)
        begin
            gwi_reg <= global_wait_insert;
            wdis_reg <= area_wait_disable;
            wcnt_reg <= area_wait_count_reg;
            wext_reg <= area_wait_extend_reg;
            cscfg_reg <= chip_select_config;
            msel_reg <= mux_region_select;
            bclk_dis_reg <= bus_clock_out_disable;
            style_reg <= strobe_style_select;
        end
    end

    // ==========================================
    // Bus clock phase and clock pin
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase_reg <= 1'b0;
            bclk_out <= 1'b1;
            bclk_pin_is_bus <= 1'b1;
        end
        else
        begin
            phase_reg <= ~phase_reg;
            bclk_out <= bclk_dis_reg ? 1'b1 : ~phase_reg;
            bclk_pin_is_bus <= ~bclk_dis_reg;
        end
    end

    // Ready pin synchroniser; level changes once stages 2 and 3 agree
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdy_sync_reg <= 3'b111;
            rdy_level_reg <= 1'b1;
        end
        else
        begin
            rdy_sync_reg <= {rdy_sync_reg[1:0], ready_n_pin};
            if (rdy_sync_reg[2] == rdy_sync_reg[1])
            begin
                rdy_level_reg <= rdy_sync_reg[2];
            end
        end
    end

    // ==========================================
    // Ready wait state: decided at the falling bus clock edge
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hold_reg <= 1'b0;
        end
        else if (state_reg == EBW_ST_RUN && fall_tick)
        begin
            if (hold_reg && rdy_level_reg)
            begin
                hold_reg <= 1'b0;
            end
            else if (bcnt_reg == EBW_LEN_1 && use_rdy_reg && !rdy_level_reg)
            begin
                hold_reg <= 1'b1;
            end
        end
    end

    // ==========================================
    // Sequencer and latched request
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= EBW_ST_IDLE;
            req_ready <= 1'b1;
            done <= 1'b0;
            rdata <= 16'h0000;
            bcnt_reg <= EBW_LEN_1;
            first_reg <= 1'b0;
            mux_reg <= 1'b0;
            use_rdy_reg <= 1'b0;
            wr_reg <= 1'b0;
            bytes_reg <= 2'b00;
            area_reg <= EBW_AREA_EXT;
            wdata_reg <= 16'h0000;
        end
        else
        begin
            done <= 1'b0;
            case (state_reg)
                EBW_ST_IDLE:
                begin
                    if (start)
                    begin
                        state_reg <= EBW_ST_RUN;
                        req_ready <= 1'b0;
                        bcnt_reg <= lif.len;
                        first_reg <= 1'b1;
                        mux_reg <= (req_area == EBW_AREA_EXT) && mux_area;
                        use_rdy_reg <= (req_area == EBW_AREA_EXT) && !wdis_reg[req_cs];
                        wr_reg <= req_write;
                        bytes_reg <= req_bytes;
                        area_reg <= req_area;
                        wdata_reg <= req_wdata;
                    end
                end
                EBW_ST_RUN:
                begin
                    // A held cycle does not advance at the rising edge
                    if (rise_tick && !hold_reg)
                    begin
                        first_reg <= 1'b0;
                        if (bcnt_reg == EBW_LEN_1)
                        begin
                            state_reg <= EBW_ST_IDLE;
                            req_ready <= 1'b1;
                            done <= 1'b1;
                            rdata <= data_in;
                        end
                        else
                        begin
                            bcnt_reg <= bcnt_reg - EBW_LEN_1;
                        end
                    end
                end
                default:
                begin
                    state_reg <= EBW_ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Address, chip select and latch pins
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_out <= 20'h0_0000;
            addr_pin_is_bus <= 20'h0_0000;
            cs_n <= 4'hf;
            cs_pin_is_bus <= 4'h0;
            ale <= 1'b0;
            byte_high_enable_n <= 1'b1;
        end
        else
        begin
            cs_pin_is_bus <= cscfg_reg;
            if (start && req_area != EBW_AREA_INT)
            begin
                if (full_mux && expansion_mode)
                begin
                    // Upper pins become ports; area window is one byte wide
                    addr_out <= {12'h000, req_addr[EBW_FULL_MUX_ADDR_BITS-1:0]};
                    addr_pin_is_bus <= 20'h0_01ff;
                end
                else
                begin
                    addr_out <= req_addr;
                    addr_pin_is_bus <= 20'hf_ffff;
                end
                byte_high_enable_n <= ~req_bytes[1];
                ale <= (req_area == EBW_AREA_EXT) && mux_area;
                if (req_area == EBW_AREA_EXT)
                begin
                    cs_n <= ~(cscfg_reg & (4'h1 << req_cs));
                end
            end
            else if (state_reg == EBW_ST_RUN && fall_tick && first_reg && !hold_reg)
            begin
                ale <= 1'b0;
            end
            else if (state_reg == EBW_ST_RUN && rise_tick && !hold_reg
                     && bcnt_reg == EBW_LEN_1)
            begin
                cs_n <= 4'hf;
                ale <= 1'b0;
            end
        end
    end

    // ==========================================
    // Data pins and strobes
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            data_out <= 16'h0000;
            data_oe_n <= 1'b1;
            rd_n <= 1'b1;
            store_low_byte_n <= 1'b1;
            store_high_byte_n <= 1'b1;
        end
        else if (start)
        begin
            if (req_area == EBW_AREA_INT)
            begin
                data_oe_n <= 1'b1;
                rd_n <= 1'b1;
                store_low_byte_n <= 1'b1;
                store_high_byte_n <= strb_off[1];
            end
            else if (req_area == EBW_AREA_EXT && mux_area)
            begin
                // Address phase on shared low data pins
                data_out <= byte_mode ? {8'h00, req_addr[7:0]} : {8'h00, req_addr[8:1]};
                data_oe_n <= 1'b0;
            end
            else
            begin
                data_out <= req_wdata;
                data_oe_n <= ~req_write;
                rd_n <= req_write;
                {store_high_byte_n, store_low_byte_n} <= strb_on;
            end
        end
        else if (state_reg == EBW_ST_RUN && rise_tick && !hold_reg)
        begin
            if (bcnt_reg == EBW_LEN_1)
            begin
                data_oe_n <= 1'b1;
                rd_n <= 1'b1;
                store_low_byte_n <= 1'b1;
                store_high_byte_n <= strb_off[1];
            end
            else if (first_reg && mux_reg)
            begin
                // Data phase; shared pins carry write data, any value is allowed
                data_out <= wdata_reg;
                data_oe_n <= ~wr_reg;
                rd_n <= wr_reg;
                store_low_byte_n <= style_eff ? ~(wr_reg & bytes_reg[0]) : ~wr_reg;
                store_high_byte_n <= style_eff ? ~(wr_reg & bytes_reg[1]) : ~bytes_reg[1];
            end
        end
    end

    // No hold request is honoured
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bus_yield_ack_n <= 1'b1;
        end
        else
        begin
            bus_yield_ack_n <= 1'b1;
        end
    end

    // ==========================================
    // Checks
    logic [4:0] len_seen_reg;
    logic [4:0] len_exp_reg;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            len_seen_reg <= 5'h00;
            len_exp_reg <= 5'h00;
        end
        else if (start)
        begin
            len_seen_reg <= 5'h00;
            len_exp_reg <= {1'b0, lif.len};
        end
        else if (state_reg == EBW_ST_RUN && rise_tick)
        begin
            len_seen_reg <= len_seen_reg + 5'h01;
            if (hold_reg)
            begin
                len_exp_reg <= len_exp_reg + 5'h01;
            end
        end
    end

    sequence s_last_low;
        state_reg == EBW_ST_RUN && fall_tick && bcnt_reg == EBW_LEN_1
            && use_rdy_reg && !rdy_level_reg && !hold_reg;
    endsequence
    sequence s_held;
        hold_reg && rise_tick;
    endsequence

    a_rdy_inserts_wait: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_last_low |=> hold_reg ##1 (state_reg == EBW_ST_RUN))
        else $error("ready low did not insert a wait");
    a_wait_holds_pins: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_held |=> $stable(addr_out) && $stable(cs_n) && $stable(rd_n)
            && $stable(ale) && $stable(store_low_byte_n) && $stable(data_out))
        else $error("pins moved during a ready wait");
    a_rdy_resumes: assert property (@(posedge clk_sys) disable iff (!rst_b)
        hold_reg && fall_tick && rdy_level_reg |=> !hold_reg)
        else $error("ready high did not resume the cycle");
    a_rdy_only_waited: assert property (@(posedge clk_sys) disable iff (!rst_b)
        hold_reg |-> use_rdy_reg)
        else $error("ready honoured for a no-wait area");
    a_bclk_toggles: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rst_b && !bclk_dis_reg ##1 !bclk_dis_reg |=> bclk_out != $past(bclk_out))
        else $error("bus clock not toggling");
    a_cs_disabled_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (cs_n | cs_pin_is_bus) == 4'hf)
        else $error("disabled chip select pin driven low");
    a_inner_pins_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_reg == EBW_ST_RUN && area_reg != EBW_AREA_EXT
            |-> cs_n == 4'hf && !ale)
        else $error("chip select or latch active on internal access");
    a_cycle_length: assert property (@(posedge clk_sys) disable iff (!rst_b)
        done |-> len_seen_reg == len_exp_reg)
        else $error("bus cycle length differs from wait setting");
    a_yield_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
        req_valid ##1 1'b1 |-> bus_yield_ack_n)
        else $error("bus yield acknowledge went low");
endmodule : ebw_ctrl
`default_nettype wire

//--- ebw_cycle_len.sv
// Decoder of bus cycle length from the wait settings
`timescale 1ns/1ps
`default_nettype none
module ebw_cycle_len
    import ebw_pkg::*;
(
    // Settings in, length out
    ebw_len_if.calc lif
);
    // ==========================================
    // Length table
    always_comb
    begin
        lif.len = EBW_LEN_2;
        if (lif.area == EBW_AREA_SFR)
        begin
            lif.len = EBW_LEN_2;
        end
        else if (lif.area == EBW_AREA_INT)
        begin
            lif.len = (lif.gwi || lif.flash_wait) ? EBW_LEN_2 : EBW_LEN_1;
        end
        else if (lif.gwi)
        begin
            lif.len = lif.mux_area ? EBW_LEN_3 : EBW_LEN_2;
        end
        else if (lif.wait_cnt == EBW_WCNT_EXT)
        begin
            case (lif.wait_ext)
                2'b00: lif.len = EBW_LEN_5;
                2'b01: lif.len = EBW_LEN_6;
                2'b10: lif.len = EBW_LEN_7;
                default: lif.len = EBW_LEN_9;
            endcase
        end
        else if (lif.mux_area)
        begin
            lif.len = (lif.wait_cnt == 2'b10) ? EBW_LEN_4 : EBW_LEN_3;
        end
        else if (lif.wait_dis && lif.wait_cnt == 2'b00)
        begin
            lif.len = lif.write ? EBW_LEN_2 : EBW_LEN_1;
        end
        else
        begin
            case (lif.wait_cnt)
                2'b00: lif.len = EBW_LEN_2;
                2'b01: lif.len = EBW_LEN_3;
                default: lif.len = EBW_LEN_4;
            endcase
        end
    end
endmodule : ebw_cycle_len
`default_nettype wire

//--- ebw_ext_mem.sv
// Behavioural external memory and ready source on the bus pins
`timescale 1ns/1ps
`default_nettype none
module ebw_ext_mem
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Bus pins and stall length
    input wire logic [3:0] cs_n,
    input wire logic rd_n,
    input wire logic [19:0] addr_out,
    input wire logic [7:0] stall_len,
    input wire logic ale,
    input wire logic [15:0] data_out,
    output logic [15:0] data_in,
    output logic ready_n_pin,
    output logic [7:0] mux_addr
);
    // ==========
    // Memory model
    logic [7:0] stall_reg;
    logic sel_reg;
    logic ale_reg;
    // Read data follows address; a released bus shows the inverse pattern
    assign data_in = addr_out[15:0] ^ ((!rd_n && cs_n != 4'hf) ? 16'ha5a5 : 16'h5a5a);
    // Pulled up except while a stall runs
    assign ready_n_pin = (stall_reg == 8'h00);
    // Load stall at chip-select fall, then count down
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stall_reg <= 8'h00;
            sel_reg <= 1'b0;
            ale_reg <= 1'b0;
            mux_addr <= 8'h00;
        end
        else
        begin
            sel_reg <= (cs_n != 4'hf);
            ale_reg <= ale;
            // Shared-pin address is taken as the latch strobe falls
            if (ale_reg && !ale)
            begin
                mux_addr <= data_out[7:0];
            end
            if (cs_n != 4'hf && !sel_reg)
                stall_reg <= stall_len;
            else if (stall_reg != 8'h00)
                stall_reg <= stall_reg - 8'h01;
        end
    end
endmodule : ebw_ext_mem
`default_nettype wire

//--- ebw_len_if.sv
// Interface between the controller and its cycle length decoder
`timescale 1ns/1ps
`default_nettype none
interface ebw_len_if;
    import ebw_pkg::*;
    ebw_area_e area;
    logic mux_area;
    logic write;
    logic wait_dis;
    logic gwi;
    logic flash_wait;
    logic [1:0] wait_cnt;
    logic [1:0] wait_ext;
    logic [3:0] len;
    // Decoder side
    modport calc (input area, mux_area, write, wait_dis, gwi, flash_wait,
                  input wait_cnt, wait_ext, output len);
    // Controller side
    modport user (output area, mux_area, write, wait_dis, gwi, flash_wait,
                  output wait_cnt, wait_ext, input len);
endinterface : ebw_len_if
`default_nettype wire

//--- ebw_pkg.sv
// Constants and types shared by the external bus wait controller
package ebw_pkg;
    // ==========================================
    // Bus mode and wait count encodings
    localparam logic [1:0] EBW_MUX_NONE = 2'b00;
    localparam logic [1:0] EBW_MUX_CS2 = 2'b01;
    localparam logic [1:0] EBW_MUX_CS1 = 2'b10;
    localparam logic [1:0] EBW_MUX_ALL = 2'b11;
    localparam logic [1:0] EBW_WCNT_EXT = 2'b11;
    // Full-space multiplex keeps only the low address byte per area
    localparam int EBW_FULL_MUX_ADDR_BITS = 8;
    // ==========================================
    // Reset values of the captured configuration
    localparam logic EBW_RST_GWI = 1'b0;
    localparam logic [3:0] EBW_RST_WAIT_DIS = 4'h0;
    localparam logic [7:0] EBW_RST_WAIT_CNT = 8'h00;
    localparam logic [7:0] EBW_RST_WAIT_EXT = 8'h00;
    localparam logic [3:0] EBW_RST_CS_CFG = 4'h0;
    localparam logic [1:0] EBW_RST_MUX_SEL = 2'b00;
    localparam logic EBW_RST_BCLK_DIS = 1'b0;
    localparam logic EBW_RST_STYLE = 1'b0;
    // ==========================================
    // Cycle lengths in bus clocks
    localparam logic [3:0] EBW_LEN_1 = 4'h1;
    localparam logic [3:0] EBW_LEN_2 = 4'h2;
    localparam logic [3:0] EBW_LEN_3 = 4'h3;
    localparam logic [3:0] EBW_LEN_4 = 4'h4;
    localparam logic [3:0] EBW_LEN_5 = 4'h5;
    localparam logic [3:0] EBW_LEN_6 = 4'h6;
    localparam logic [3:0] EBW_LEN_7 = 4'h7;
    localparam logic [3:0] EBW_LEN_9 = 4'h9;
    // Bus clock runs at half of clk_sys: two ticks per bus clock
    localparam int EBW_TICKS_PER_BCLK = 2;
    // Pin synchroniser depth for the ready input
    localparam int EBW_SYNC_STAGES = 3;
    // ==========================================
    // Kinds of access and controller states
    typedef enum logic [1:0] {EBW_AREA_EXT, EBW_AREA_SFR, EBW_AREA_INT} ebw_area_e;
    typedef enum logic {EBW_ST_IDLE, EBW_ST_RUN} ebw_state_e;
endpackage : ebw_pkg

//--- tb.sv
// Self-checking bench for the external bus wait controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ebw_pkg::*;
    // ==========
    // Stimulus and observed pins
    logic clk_sys, rst_b, req_ready, done, data_oe_n, rd_n, ale, ready_n_pin;
    logic bus_clock_out_disable = 1'b0, global_wait_insert = 1'b0, data_flash_wait = 1'b0;
    logic strobe_style_select = 1'b0;
    logic byte_mode = 1'b0, expansion_mode = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [1:0] mux_region_select = 2'h0, req_cs = 2'h0, req_bytes = 2'h3;
    logic [3:0] area_wait_disable = 4'h0, chip_select_config = 4'ha, cs_n, cs_pin_is_bus;
    logic [7:0] area_wait_count_reg = 8'h00, area_wait_extend_reg = 8'h00, stall_len = 8'h00;
    logic [19:0] req_addr = 20'h0_0000, addr_out, addr_pin_is_bus;
    logic [15:0] req_wdata = 16'h1234, rdata, data_out, data_in;
    logic store_low_byte_n, store_high_byte_n, byte_high_enable_n;
    logic [7:0] mux_addr;
    logic bus_yield_ack_n, bclk_out, bclk_pin_is_bus;
    ebw_area_e req_area = EBW_AREA_EXT;
    int bad_count = 0, num_checks = 0, n;
    ebw_ctrl ebw_ctrl_inst (.*);
    ebw_ext_mem ebw_ext_mem_inst (.*);
    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Comparison and verdict
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : chk
    task automatic complete_run;
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // Wait settings, applied at an edge while idle
    task automatic cfg(input logic [3:0] wd, input logic [7:0] cnt, input logic [7:0] ext,
                       input logic g, input logic [1:0] m);
        @(posedge clk_sys);
        area_wait_disable <= wd;
        area_wait_count_reg <= cnt;
        area_wait_extend_reg <= ext;
        global_wait_insert <= g;
        mux_region_select <= m;
    endtask : cfg
    // One access; n counts clocks from take to done
    task automatic acc(input ebw_area_e ar, input logic wr, input logic [19:0] a,
                       input logic [7:0] st, input int el);
        logic [19:0] pa;
        logic [19:0] ta;
        logic [3:0] tc;
        logic pb;
        int k;
        pa = addr_out;
        pb = byte_high_enable_n;
        @(posedge clk_sys);
        req_area <= ar;
        req_write <= wr;
        req_addr <= a;
        req_cs <= a[19:18];
        stall_len <= st;
        req_valid <= 1'b1;
        for (k = 0; k < 20 && req_ready !== 1'b0; k++)
        begin
            @(posedge clk_sys);
            #1;
        end
        ta = addr_out;
        tc = cs_n;
        if (wr && mux_region_select === 2'h0)
            chk(data_out === req_wdata && data_oe_n === 1'b0 && store_low_byte_n === 1'b0
                && store_high_byte_n === 1'b0, "write pins");
        if (ar == EBW_AREA_EXT && mux_region_select === 2'h3)
            chk(ale === 1'b1, "address latch");
        n = 0;
        while (done !== 1'b1 && k < 20 && n < 40)
        begin
            @(posedge clk_sys);
            req_valid <= 1'b0;
            #1;
            n++;
            if (done !== 1'b1 && st != 8'h00)
                chk(addr_out === ta && cs_n === tc, "pins moved in wait");
            if (ar != EBW_AREA_EXT)
                chk(cs_n === 4'hf && ale === 1'b0, "internal pins");
            if (ar == EBW_AREA_INT)
                chk(rd_n === 1'b1 && data_oe_n === 1'b1 && addr_out === pa
                    && byte_high_enable_n === pb, "internal hold");
        end
        if (k >= 20 || n >= 40)
        begin
            chk(1'b0, "bus hung");
            complete_run();
        end
        if (el > 0)
            chk(n == 2 * el, "cycle length");
        if (ar == EBW_AREA_EXT && !wr && byte_mode === 1'b0 && mux_region_select === 2'h0)
            chk(rdata === (a[15:0] ^ 16'ha5a5), "read data");
    endtask : acc
    // Reset defaults and chip-select pin use
    task automatic t_reset;
        acc(EBW_AREA_EXT, 1'b0, 20'h4_0042, 8'h00, 2);
        chk(bus_yield_ack_n === 1'b1 && cs_pin_is_bus === 4'ha, "reset pins");
        @(posedge clk_sys);
        chip_select_config <= 4'hf;
    endtask : t_reset
    // Separate bus wait table
    task automatic t_sep;
        int i;
        cfg(4'h1, 8'h00, 8'h00, 1'b0, 2'h0);
        acc(EBW_AREA_EXT, 1'b0, 20'h0_0010, 8'h00, 1);
        acc(EBW_AREA_EXT, 1'b1, 20'h0_0012, 8'h00, 2);
        for (i = 0; i < 7; i++)
        begin
            cfg(4'h0, (i < 3) ? 8'(i) : 8'h03, 8'(i - 3), 1'b0, 2'h0);
            acc(EBW_AREA_EXT, 1'b0, 20'h0_0020, 8'h00, (i == 6) ? 9 : i + 2);
        end
        cfg(4'h0, 8'h00, 8'h00, 1'b1, 2'h0);
        acc(EBW_AREA_EXT, 1'b0, 20'h0_0040, 8'h00, 2);
    endtask : t_sep
    // Ready stall, honoured and ignored
    task automatic t_ready;
        cfg(4'h0, 8'h02, 8'h00, 1'b0, 2'h0);
        acc(EBW_AREA_EXT, 1'b0, 20'h0_0050, 8'h0c, 0);
        chk(n > 8 && n < 30, "ready wait");
        cfg(4'h1, 8'h02, 8'h00, 1'b0, 2'h0);
        acc(EBW_AREA_EXT, 1'b0, 20'h0_0054, 8'h0c, 4);
        // Let the ready stall drain before the next scenario
        repeat (16) @(posedge clk_sys);
    endtask : t_ready
    // Register and internal accesses, bus clock pin
    task automatic t_int;
        logic b;
        cfg(4'h0, 8'h00, 8'h00, 1'b0, 2'h0);
        acc(EBW_AREA_EXT, 1'b1, 20'h0_0066, 8'h00, 2);
        acc(EBW_AREA_SFR, 1'b1, 20'h0_0400, 8'h00, 2);
        acc(EBW_AREA_INT, 1'b0, 20'h0_2000, 8'h00, 1);
        @(posedge clk_sys);
        data_flash_wait <= 1'b1;
        acc(EBW_AREA_INT, 1'b0, 20'h0_2002, 8'h00, 2);
        b = bclk_out;
        @(posedge clk_sys);
        #1;
        chk(bclk_out !== b && bclk_pin_is_bus === 1'b1, "bus clock");
        @(posedge clk_sys);
        bus_clock_out_disable <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk(bclk_pin_is_bus === 1'b0, "bus clock port");
    endtask : t_int
    // Multiplexed bus lengths and regions
    task automatic t_mux;
        int m;
        @(posedge clk_sys);
        byte_mode <= 1'b1;
        expansion_mode <= 1'b1;
        for (m = 0; m < 4; m++)
        begin
            cfg(4'h0, (m < 3) ? 8'(m) : 8'h00, 8'h00, m == 3, 2'h3);
            acc(EBW_AREA_EXT, 1'b0, 20'h0_0070, 8'h00, (m == 2) ? 4 : 3);
        end
        chk(addr_pin_is_bus === 20'h0_01ff, "full mux pins");
        chk(mux_addr === 8'h70, "latched address");
        for (m = 1; m < 3; m++)
        begin
            cfg(4'h0, 8'h00, 8'h00, 1'b0, 2'(m));
            acc(EBW_AREA_EXT, 1'b0, 20'h8_0010, 8'h00, (m == 1) ? 3 : 2);
        end
    endtask : t_mux
    // Main sequence
    initial
    begin
        rst_b = 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_sep();
        t_ready();
        t_int();
        t_mux();
        complete_run();
    end
endmodule : tb
`default_nettype wire
